// [design/lds_pkg.sv]
// Package: register map, field positions, reset values and states of the device status block
package lds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
    // Status register field positions
    localparam int BIT_DUPLEX = 0;
    localparam int BIT_LINK = 1;
    localparam int BIT_KIND_LO = 2;
    localparam int BIT_TXPAUSE = 4;
    localparam int BIT_PWRDN = 5;
    localparam int BIT_SPEED_LO = 6;
    localparam int BIT_CPL_BLOCK = 8;
    localparam int BIT_INIT_DONE = 9;
    localparam int BIT_RST_SEEN = 10;
    localparam int BIT_MASTER_EN = 19;
    localparam int BIT_QDMA = 31;
    // Reset values
    localparam logic RST_PWRDN = 1'b1;
    localparam logic RST_INIT_DONE = 1'b0;
    localparam logic RST_RST_SEEN = 1'b1;
    localparam logic RST_MASTER_EN = 1'b1;
    localparam logic RST_QDMA = 1'b1;
    localparam logic [1:0] RST_KIND = 2'h0;
    // Interrupt status bit positions
    localparam int IRQ_W = 4;
    localparam int IRQ_CPL_BLOCK = 0;
    localparam int IRQ_INIT_DONE = 1;
    localparam int IRQ_RST_SEEN = 2;
    localparam int IRQ_LINK_CHG = 3;
    // Transmit pause tracker states
    typedef enum logic [0:0] {
        LDS_RUN = 1'b0,
        LDS_PAUSED = 1'b1
    } lds_pause_t;
endpackage

// [design/lds_tx_pause.sv]
// Transmit pause tracker driven by received XOFF, XON and pause timer expiry
module lds_tx_pause (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sym_fc_active,
    input wire logic xoff_rx,
    input wire logic xon_rx,
    input wire logic pause_expired,
    output logic tx_paused_flag
);
    lds_pkg::lds_pause_t state_q;
    lds_pkg::lds_pause_t state_d;

    // Next state; leaving pause on whichever of XON or expiry comes first
    always_comb begin
        state_d = state_q;
        case (state_q)
            lds_pkg::LDS_RUN: begin
                // RULE4: pause on XOFF
                if (sym_fc_active && xoff_rx) begin
                    state_d = lds_pkg::LDS_PAUSED;
                end
            end
            lds_pkg::LDS_PAUSED: begin
                // RULE5: resume on XON/expiry
                if (xon_rx || pause_expired || !sym_fc_active) begin
                    state_d = lds_pkg::LDS_RUN;
                end
            end
            default: state_d = lds_pkg::LDS_RUN;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= lds_pkg::LDS_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    assign tx_paused_flag = (state_q == lds_pkg::LDS_PAUSED);

    // RULE4: XOFF pauses next cycle
    property p_xoff_pauses;
        @(posedge core_clk) disable iff (reset)
        (state_q == lds_pkg::LDS_RUN && sym_fc_active && xoff_rx) |=> tx_paused_flag;
    endproperty
    a_xoff_pauses: assert property (p_xoff_pauses) else $error("XOFF did not pause"); // RULE4

    // RULE5: XON or expiry ends pause
    property p_resume;
        @(posedge core_clk) disable iff (reset)
        (tx_paused_flag && (xon_rx || pause_expired)) |=> !tx_paused_flag;
    endproperty
    a_resume: assert property (p_resume) else $error("Pause not released"); // RULE5
endmodule

// [design/lds_status.sv]
// Device status register block with plain register port and interrupt logic
// ****************************************************************
// Notes on behaviour
// RULE1: bit 0 shows MAC duplex, 1 full, 0 half.
// RULE2: bit 1 shows link established; valid only while link-up-force is set.
// RULE3: bits 3:2 give transceiver kind from the NVM init control word.
// RULE4: bit 4 sets when XOFF pauses transmit under symmetric flow control.
// RULE5: bit 4 clears on pause timer expiry or XON, whichever first.
// RULE6: bit 5 is 1 when transceiver powered down, mirrors power pin, resets 1.
// RULE7: power-down indication is valid only after a transceiver reset was seen.
// RULE8: speed 00 is 10, 01 is 100, 10 and 11 are 1000 Mb/s.
// RULE9: speed shows negotiated speed unless software forced the MAC speed.
// RULE10: bit 8 sets on poisoned or failed completion; cleared only by PCI reset.
// RULE11: bit 9 sets when LAN initialisation from flash completes; resets 0.
// RULE12: software clears the init-done bit after observing it.
// RULE13: bit 10 sets on any transceiver reset, cleared by writing 0; resets 1.
// RULE14: bit 19 clears when master disabled and nothing pending, else 1.
// RULE15: reserved bits read zero and ignore writes.
// RULE16: bit 31 is the NVM-loaded quarter DMA clock capability; resets 1.
// RULE17: volatile bits follow sources live; reads have no side effect.
// ****************************************************************
//
// Design decision made here: the strobed register port.
module lds_status (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pci_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic duplex_flag,
    input wire logic link_established_flag,
    input wire logic link_up_force,
    input wire logic nvm_load,
    input wire logic [1:0] nvm_transceiver_kind,
    input wire logic nvm_quarter_dma,
    input wire logic sym_fc_active,
    input wire logic xoff_rx,
    input wire logic xon_rx,
    input wire logic pause_expired,
    input wire logic transceiver_power_control_pin,
    input wire logic [1:0] link_speed,
    input wire logic speed_forced,
    input wire logic [1:0] forced_speed,
    input wire logic cpl_error,
    input wire logic init_done_evt,
    input wire logic transceiver_reset_evt,
    input wire logic master_disable,
    input wire logic master_pending
);
    // ****************************************************************
    // Sticky and loaded state
    // ****************************************************************
    logic cpl_block_q;
    logic cpl_block_d;
    logic init_done_q;
    logic init_done_d;
    logic rst_seen_q;
    logic rst_seen_d;
    logic rst_ever_q;
    logic rst_ever_d;
    logic [1:0] kind_q;
    logic [1:0] kind_d;
    logic qdma_q;
    logic qdma_d;
    logic master_en_q;
    logic master_en_d;
    logic pwrdn_q;
    logic pwrdn_d;
    logic link_q;
    logic link_d;
    logic [lds_pkg::IRQ_W-1:0] irq_stat_q;
    logic [lds_pkg::IRQ_W-1:0] irq_stat_d;
    logic [lds_pkg::IRQ_W-1:0] irq_mask_q;
    logic [lds_pkg::IRQ_W-1:0] irq_mask_d;
    logic [lds_pkg::IRQ_W-1:0] irq_evt;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] status_word;
    logic tx_paused_flag;
    logic wr_status;
    logic wr_irq_stat;
    logic wr_irq_mask;

    // Address compare shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // Transmit pause tracker
    lds_tx_pause u_pause (
        .core_clk(core_clk),
        .reset(reset),
        .sym_fc_active(sym_fc_active),
        .xoff_rx(xoff_rx),
        .xon_rx(xon_rx),
        .pause_expired(pause_expired),
        .tx_paused_flag(tx_paused_flag)
    );

    // Write strobes per register
    always_comb begin
        wr_status = 1'b0;
        wr_irq_stat = 1'b0;
        wr_irq_mask = 1'b0;
        if (reg_wr && hit(reg_addr, lds_pkg::ADDR_STATUS)) begin
            wr_status = 1'b1;
        end else if (reg_wr && hit(reg_addr, lds_pkg::ADDR_IRQ_STAT)) begin
            wr_irq_stat = 1'b1;
        end else if (reg_wr && hit(reg_addr, lds_pkg::ADDR_IRQ_MASK)) begin
            wr_irq_mask = 1'b1;
        end
    end

    // ****************************************************************
    // Status bit next values
    // ****************************************************************
    // Hardware set wins over software clear so no event is lost
    always_comb begin
        // RULE10: sticky completion block
        cpl_block_d = cpl_block_q | cpl_error;
        // RULE11: init done sets
        init_done_d = init_done_q;
        // RULE12: software write of 0 clears
        if (wr_status && !reg_wdata[lds_pkg::BIT_INIT_DONE]) begin
            init_done_d = 1'b0;
        end
        if (init_done_evt) begin
            init_done_d = 1'b1;
        end
        // RULE13: reset seen, cleared by 0
        rst_seen_d = rst_seen_q;
        if (wr_status && !reg_wdata[lds_pkg::BIT_RST_SEEN]) begin
            rst_seen_d = 1'b0;
        end
        if (transceiver_reset_evt) begin
            rst_seen_d = 1'b1;
        end
        // RULE7: qualify power indication
        rst_ever_d = rst_ever_q | transceiver_reset_evt;
        // RULE3: kind from NVM
        kind_d = nvm_load ? nvm_transceiver_kind : kind_q;
        // RULE16: capability from NVM
        qdma_d = nvm_load ? nvm_quarter_dma : qdma_q;
        // RULE14: master enable status
        master_en_d = !(master_disable && !master_pending);
        // RULE6: mirror power pin
        pwrdn_d = transceiver_power_control_pin;
        link_d = link_established_flag & link_up_force;
    end

    // Status registers; completion block survives all but PCI reset
    always_ff @(posedge core_clk) begin
        if (pci_reset) begin
            cpl_block_q <= 1'b0;
        end else begin
            cpl_block_q <= cpl_block_d;
        end
        if (reset) begin
            init_done_q <= lds_pkg::RST_INIT_DONE;
            rst_seen_q <= lds_pkg::RST_RST_SEEN;
            rst_ever_q <= 1'b0;
            kind_q <= lds_pkg::RST_KIND;
            qdma_q <= lds_pkg::RST_QDMA;
            master_en_q <= lds_pkg::RST_MASTER_EN;
            pwrdn_q <= lds_pkg::RST_PWRDN;
            link_q <= 1'b0;
        end else begin
            init_done_q <= init_done_d;
            rst_seen_q <= rst_seen_d;
            rst_ever_q <= rst_ever_d;
            kind_q <= kind_d;
            qdma_q <= qdma_d;
            master_en_q <= master_en_d;
            pwrdn_q <= pwrdn_d;
            link_q <= link_d;
        end
    end

    // ****************************************************************
    // Status word assembly
    // ****************************************************************
    // Reserved positions stay zero since only named bits are placed
    always_comb begin
        status_word = 32'h0000_0000;
        // RULE1: live duplex
        status_word[lds_pkg::BIT_DUPLEX] = duplex_flag;
        // RULE2: link gated by force bit
        status_word[lds_pkg::BIT_LINK] = link_q;
        status_word[lds_pkg::BIT_KIND_LO +: 2] = kind_q;
        status_word[lds_pkg::BIT_TXPAUSE] = tx_paused_flag;
        // RULE7: reads 1 until a transceiver reset qualified it
        status_word[lds_pkg::BIT_PWRDN] = rst_ever_q ? pwrdn_q : lds_pkg::RST_PWRDN;
        // RULE8: 2-bit code passes as is
        // RULE9: forced speed overrides
        status_word[lds_pkg::BIT_SPEED_LO +: 2] = speed_forced ? forced_speed : link_speed;
        status_word[lds_pkg::BIT_CPL_BLOCK] = cpl_block_q;
        status_word[lds_pkg::BIT_INIT_DONE] = init_done_q;
        status_word[lds_pkg::BIT_RST_SEEN] = rst_seen_q;
        status_word[lds_pkg::BIT_MASTER_EN] = master_en_q;
        status_word[lds_pkg::BIT_QDMA] = qdma_q;
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Event levels and link bit changes feed sticky status; set beats write-one clear
    always_comb begin
        irq_evt = '0;
        irq_evt[lds_pkg::IRQ_CPL_BLOCK] = cpl_error;
        irq_evt[lds_pkg::IRQ_INIT_DONE] = init_done_evt;
        irq_evt[lds_pkg::IRQ_RST_SEEN] = transceiver_reset_evt;
        irq_evt[lds_pkg::IRQ_LINK_CHG] = link_d ^ link_q;
        irq_stat_d = irq_stat_q;
        if (wr_irq_stat) begin
            irq_stat_d = irq_stat_q & ~reg_wdata[lds_pkg::IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_evt;
        irq_mask_d = wr_irq_mask ? reg_wdata[lds_pkg::IRQ_W-1:0] : irq_mask_q;
    end

    // Interrupt registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // Read port
    // ****************************************************************
    // RULE17: reads have no side effect
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd && hit(reg_addr, lds_pkg::ADDR_STATUS)) begin
            rdata_d = status_word;
        end else if (reg_rd && hit(reg_addr, lds_pkg::ADDR_IRQ_STAT)) begin
            rdata_d[lds_pkg::IRQ_W-1:0] = irq_stat_q;
        end else if (reg_rd && hit(reg_addr, lds_pkg::ADDR_IRQ_MASK)) begin
            rdata_d[lds_pkg::IRQ_W-1:0] = irq_mask_q;
        end
    end

    // Read data register, valid one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // RULE10: completion block holds
    property p_cpl_sticky;
        @(posedge core_clk) disable iff (reset || pci_reset)
        cpl_error |=> cpl_block_q [*2];
    endproperty
    a_cpl_sticky: assert property (p_cpl_sticky) else $error("Completion block lost"); // RULE10

    // RULE11: init done event sets bit
    property p_init_done;
        @(posedge core_clk) disable iff (reset)
        init_done_evt |=> init_done_q;
    endproperty
    a_init_done: assert property (p_init_done) else $error("Init done not set"); // RULE11

    // RULE13: write 0 clears reset seen
    property p_rst_clear;
        @(posedge core_clk) disable iff (reset)
        (wr_status && !reg_wdata[lds_pkg::BIT_RST_SEEN] && !transceiver_reset_evt)
            |=> !rst_seen_q;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("Reset seen not cleared"); // RULE13

    // RULE14: master enable status
    property p_master;
        @(posedge core_clk) disable iff (reset)
        (master_disable && !master_pending) |=> !master_en_q;
    endproperty
    a_master: assert property (p_master) else $error("Master status wrong"); // RULE14

    // RULE15: reserved bits zero
    property p_reserved;
        @(posedge core_clk) disable iff (reset)
        $past(reg_rd) |-> (reg_rdata[30:20] == 11'h000 && reg_rdata[18:11] == 8'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bit set"); // RULE15

    // RULE9: read returns forced speed
    property p_speed;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && hit(reg_addr, lds_pkg::ADDR_STATUS) && speed_forced)
            |=> reg_rdata[lds_pkg::BIT_SPEED_LO +: 2] == $past(forced_speed);
    endproperty
    a_speed: assert property (p_speed) else $error("Forced speed not shown"); // RULE9

    // RULE6: power bit follows pin once qualified
    property p_pwr;
        @(posedge core_clk) disable iff (reset)
        rst_ever_q |=> pwrdn_q == $past(transceiver_power_control_pin);
    endproperty
    a_pwr: assert property (p_pwr) else $error("Power bit not mirrored"); // RULE6

    // RULE17: read leaves sticky bits unchanged
    property p_read_quiet;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && !reg_wr && !init_done_evt && !transceiver_reset_evt)
            |=> (init_done_q == $past(init_done_q) && rst_seen_q == $past(rst_seen_q));
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("Read changed state"); // RULE17

    // Status read strobe, the first step of every read-back check below
    sequence s_status_read;
        reg_rd && hit(reg_addr, lds_pkg::ADDR_STATUS);
    endsequence

    // RULE1: read shows live duplex
    property p_duplex;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> reg_rdata[lds_pkg::BIT_DUPLEX] == $past(duplex_flag);
    endproperty
    a_duplex: assert property (p_duplex) else $error("Duplex bit wrong"); // RULE1

    // RULE13: transceiver reset sets bit
    property p_rst_set;
        @(posedge core_clk) disable iff (reset)
        transceiver_reset_evt |=> rst_seen_q;
    endproperty
    a_rst_set: assert property (p_rst_set) else $error("Reset seen not set"); // RULE13

    // RULE3: load captures NVM fields
    property p_nvm_load;
        @(posedge core_clk) disable iff (reset)
        nvm_load |=> (kind_q == $past(nvm_transceiver_kind)
            && qdma_q == $past(nvm_quarter_dma));
    endproperty
    a_nvm_load: assert property (p_nvm_load) else $error("NVM fields not loaded"); // RULE3 RULE16

    // RULE14: enable status otherwise set
    property p_master_on;
        @(posedge core_clk) disable iff (reset)
        !(master_disable && !master_pending) |=> master_en_q;
    endproperty
    a_master_on: assert property (p_master_on) else $error("Master status not set"); // RULE14
endmodule

// [tb/tb_lds_status.sv]
// Self-checking bench for the device status register block
module tb_lds_status;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Stimulus signals and counters
    // ****************************************************************
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic pci_reset = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic irq;
    logic duplex_flag = 1'h0, link_established_flag = 1'h0, link_up_force = 1'h0;
    logic nvm_load = 1'h0, nvm_quarter_dma = 1'h1, speed_forced = 1'h0;
    logic [1:0] nvm_transceiver_kind = 2'h0, link_speed = 2'h0, forced_speed = 2'h0;
    logic sym_fc_active = 1'h0, xoff_rx = 1'h0, xon_rx = 1'h0, pause_expired = 1'h0;
    logic transceiver_power_control_pin = 1'h0, cpl_error = 1'h0;
    logic init_done_evt = 1'h0, transceiver_reset_evt = 1'h0;
    logic master_disable = 1'h0, master_pending = 1'h0;
    logic [31:0] data;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // One row: duplex, link, force, speed, forced flag, forced speed, pin, expected bits 7:0
    typedef struct packed {
        logic dup; logic lnk; logic frc; logic [1:0] spd;
        logic sf; logic [1:0] fs; logic pin; logic [7:0] exp;
    } lds_row_t;
    lds_row_t rows [6] = '{
        '{1'h1, 1'h1, 1'h1, 2'h0, 1'h0, 2'h0, 1'h0, 8'h03},
        '{1'h0, 1'h1, 1'h0, 2'h1, 1'h0, 2'h3, 1'h1, 8'h60},
        '{1'h1, 1'h0, 1'h1, 2'h2, 1'h0, 2'h0, 1'h0, 8'h81},
        '{1'h0, 1'h1, 1'h1, 2'h3, 1'h0, 2'h1, 1'h1, 8'he2},
        '{1'h0, 1'h0, 1'h0, 2'h3, 1'h1, 2'h1, 1'h0, 8'h40},
        '{1'h1, 1'h1, 1'h1, 2'h0, 1'h1, 2'h2, 1'h0, 8'h83}};

    // Free-running 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    lds_status lds_status_i (
        .core_clk(core_clk), .reset(reset), .pci_reset(pci_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .duplex_flag(duplex_flag),
        .link_established_flag(link_established_flag), .link_up_force(link_up_force),
        .nvm_load(nvm_load), .nvm_transceiver_kind(nvm_transceiver_kind),
        .nvm_quarter_dma(nvm_quarter_dma), .sym_fc_active(sym_fc_active),
        .xoff_rx(xoff_rx), .xon_rx(xon_rx), .pause_expired(pause_expired),
        .transceiver_power_control_pin(transceiver_power_control_pin),
        .link_speed(link_speed), .speed_forced(speed_forced), .forced_speed(forced_speed),
        .cpl_error(cpl_error), .init_done_evt(init_done_evt),
        .transceiver_reset_evt(transceiver_reset_evt), .master_disable(master_disable),
        .master_pending(master_pending)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Verdict in one place, also reached by the hang guard
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    // One-cycle event pulse, selected by index
    task automatic fire(input int k);
        @(posedge core_clk);
        case (k)
            0: cpl_error <= 1'h1;
            1: init_done_evt <= 1'h1;
            2: transceiver_reset_evt <= 1'h1;
            3: xoff_rx <= 1'h1;
            4: xon_rx <= 1'h1;
            5: pause_expired <= 1'h1;
            default: nvm_load <= 1'h1;
        endcase
        @(posedge core_clk);
        {cpl_error, init_done_evt, transceiver_reset_evt, xoff_rx} <= 4'h0;
        {xon_rx, pause_expired, nvm_load} <= 3'h0;
    endtask

    task automatic st(output logic [31:0] d);
        rd(lds_pkg::ADDR_STATUS, d);
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'h0;
        pci_reset <= 1'h0;
        @(posedge core_clk);
        #1;
        check("rdata_idle", 32'h0000_0000, reg_rdata);
        st(data);
        check("status_reset", 32'h8008_0420, data);
        rd(8'h44, data);
        check("unmapped_read", 32'h0000_0000, data);
        // Power-down bit only tells the pin once a transceiver reset was seen
        fire(2);
        st(data);
        check("pwrdn_valid", 32'h0000_0000, data & 32'h0000_0020);
        foreach (rows[i]) begin
            @(posedge core_clk);
            duplex_flag <= rows[i].dup;
            link_established_flag <= rows[i].lnk;
            link_up_force <= rows[i].frc;
            link_speed <= rows[i].spd;
            speed_forced <= rows[i].sf;
            forced_speed <= rows[i].fs;
            transceiver_power_control_pin <= rows[i].pin;
            repeat (2) @(posedge core_clk);
            st(data);
            check("status_row", {24'h00_0000, rows[i].exp}, data & 32'h0000_00e3);
        end
        // Init-done and reset-seen bits: set by events, cleared by writing zero only
        fire(1);
        st(data);
        check("init_done_set", 32'h0000_0600, data & 32'h0000_0600);
        st(data);
        check("read_no_side", 32'h0000_0600, data & 32'h0000_0600);
        wr(lds_pkg::ADDR_STATUS, 32'hffff_ffff);
        st(data);
        check("write_ones", 32'h0000_0600, data & 32'h0000_0600);
        check("reserved_zero", 32'h0000_0000, data & 32'h7ff7_f800);
        wr(lds_pkg::ADDR_STATUS, 32'h0000_0400);
        st(data);
        check("init_done_clr", 32'h0000_0400, data & 32'h0000_0600);
        wr(lds_pkg::ADDR_STATUS, 32'h0000_0000);
        st(data);
        check("rst_seen_clr", 32'h0000_0000, data & 32'h0000_0600);
        fire(2);
        st(data);
        check("rst_seen_set", 32'h0000_0400, data & 32'h0000_0600);
        // Pause flag against both release causes, then without flow control
        for (int k = 4; k <= 5; k++) begin
            @(posedge core_clk);
            sym_fc_active <= 1'h1;
            fire(3);
            st(data);
            check("tx_paused_set", 32'h0000_0010, data & 32'h0000_0010);
            fire(k);
            st(data);
            check("tx_paused_clr", 32'h0000_0000, data & 32'h0000_0010);
        end
        @(posedge core_clk);
        sym_fc_active <= 1'h0;
        fire(3);
        st(data);
        check("tx_paused_nofc", 32'h0000_0000, data & 32'h0000_0010);
        // Master enable: only disabled with nothing pending clears it
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            master_disable <= (m != 2);
            master_pending <= (m == 0);
            repeat (2) @(posedge core_clk);
            st(data);
            check("master_en", (m == 1) ? 32'h0000_0000 : 32'h0008_0000,
                  data & 32'h0008_0000);
        end
        // Loaded fields take their values only on the load pulse
        @(posedge core_clk);
        nvm_transceiver_kind <= 2'h1;
        nvm_quarter_dma <= 1'h0;
        fire(6);
        st(data);
        check("nvm_fields", 32'h0000_0004, data & 32'h8000_000c);
        // Interrupt: raise while masked, unmask, then clear by writing one
        wr(lds_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        wr(lds_pkg::ADDR_IRQ_STAT, 32'h0000_000f);
        fire(0);
        rd(lds_pkg::ADDR_IRQ_STAT, data);
        check("irq_stat", 32'h0000_0001, data);
        check("irq_masked", 32'h0000_0000, {31'h0000_0000, irq});
        st(data);
        check("cpl_block_set", 32'h0000_0100, data & 32'h0000_0100);
        wr(lds_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge core_clk);
        #1;
        check("irq_on", 32'h0000_0001, {31'h0000_0000, irq});
        wr(lds_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        @(posedge core_clk);
        #1;
        check("irq_off", 32'h0000_0000, {31'h0000_0000, irq});
        // Remaining causes: init done, transceiver reset and a link bit change
        @(posedge core_clk);
        link_up_force <= 1'h0;
        fire(1);
        fire(2);
        rd(lds_pkg::ADDR_IRQ_STAT, data);
        check("irq_causes", 32'h0000_000e, data);
        check("irq_still_masked", 32'h0000_0000, {31'h0000_0000, irq});
        rd(lds_pkg::ADDR_IRQ_MASK, data);
        check("irq_mask_rd", 32'h0000_0001, data);
        // Core reset leaves the blocked bit; only the bus reset clears it
        @(posedge core_clk);
        reset <= 1'h1;
        @(posedge core_clk);
        reset <= 1'h0;
        st(data);
        check("cpl_keep", 32'h0000_0100, data & 32'h0000_0100);
        @(posedge core_clk);
        pci_reset <= 1'h1;
        @(posedge core_clk);
        pci_reset <= 1'h0;
        st(data);
        check("cpl_pci_clr", 32'h0000_0000, data & 32'h0000_0100);
        wrap_up();
    end
endmodule
